// File: design/vip_pkg.sv
// constants and register map of the vectored interrupt prioritizer
package vip_pkg;
	localparam int N_SRC  = 32;
	localparam int N_SLOT = 16;
	localparam int SRC_W  = 5;
	localparam int IDX_W  = 4;
	localparam int ADDR_W = 12;

	// request channel with no peripheral behind it
	localparam int SW_ONLY_CH = 1;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [11:0] OFF_NORM_STAT = 12'h000;
	localparam logic [11:0] OFF_FAST_STAT = 12'h004;
	localparam logic [11:0] OFF_RAW_STAT  = 12'h008;
	localparam logic [11:0] OFF_ENABLE    = 12'h00c;
	localparam logic [11:0] OFF_CLASS     = 12'h010;
	localparam logic [11:0] OFF_SOFT      = 12'h014;
	localparam logic [11:0] OFF_DEF_ADDR  = 12'h018;
	localparam logic [11:0] OFF_VECT_ADDR = 12'h01c;
	localparam logic [11:0] OFF_EVT_STAT  = 12'h020;
	localparam logic [11:0] OFF_EVT_MASK  = 12'h024;
	localparam logic [11:0] OFF_SLOT_ADDR = 12'h100;
	localparam logic [11:0] OFF_SLOT_CTL  = 12'h200;
	localparam logic [11:0] SLOT_SPAN     = 12'h040;

	// slot control fields
	localparam int SLOT_SRC_LSB = 0;
	localparam int SLOT_EN_BIT  = 5;

	// event bits
	localparam int EVT_FAST = 0;
	localparam int EVT_NORM = 1;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [1:0]  RST_EVT   = 2'h0;
	localparam logic [4:0]  RST_SRC   = 5'h00;
	localparam logic        RST_BIT   = 1'b0;
endpackage : vip_pkg

// File: design/vip_pick_if.sv
// slot hits and the winning slot between top and priority picker
`timescale 1ns/1ps
interface vip_pick_if;
	logic [15:0] hit;
	logic        valid;
	logic [3:0]  index;

	modport req  (output hit, input valid, input index);
	modport pick (input hit, output valid, output index);
endinterface : vip_pick_if

// File: design/vip_slot_pick.sv
// fixed priority picker over the vectored slots
`timescale 1ns/1ps
module vip_slot_pick (
	vip_pick_if.pick pk
);
	// ****************************************
	// lowest index wins
	// ****************************************
	always_comb begin
		pk.valid = 1'b0;
		pk.index = 4'h0;
		// walk downward so the last hit kept is the lowest slot
		for (int i = vip_pkg::N_SLOT - 1; i >= 0; i--) begin
			if (pk.hit[i]) begin
				pk.valid = 1'b1;
				pk.index = 4'(i);  // [RULE6]
			end
		end
	end
endmodule : vip_slot_pick

// File: design/vip_request_prioritizer.sv
// request prioritizer top: sync, classing, slots, apb registers
`timescale 1ns/1ps

// How it works
// RULE1 - each source is fast, vectored or non-vectored
// RULE2 - software may reassign class and slots anytime
// RULE3 - fast wins; fast sources ORed to output
// RULE4 - status word shows active fast sources
// RULE5 - sixteen slots, any source in any slot
// RULE6 - slot 0 highest, slot 15 lowest
// RULE7 - vectored below fast, above non-vectored
// RULE8 - normal output ORs vectored and non-vectored
// RULE9 - vector read gives winning slot address
// RULE10 - no vectored winner gives default address
// RULE11 - status shows active normal class sources
// RULE12 - one request line per peripheral
// RULE13 - channel one takes software requests only
// RULE14 - sample inputs, register outputs, clear on reset; pslverr_out is combinational, pready_out tied high
// RULE15 - vector read value refreshed every cycle
module vip_request_prioritizer (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [31:0] req_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             fast_request_out,
	output logic             normal_request_out,
	output logic             irq_out
);
	// ****************************************
	// state
	// ****************************************
	logic [31:0] req_s1_q;
	logic [31:0] req_s2_q;
	logic [31:0] enable_q;
	logic [31:0] class_q;
	logic [31:0] soft_q;
	logic [31:0] default_q;
	logic [31:0] vect_addr_q;
	logic [31:0] slot_addr_q [16];
	logic [4:0]  slot_src_q  [16];
	logic [15:0] slot_en_q;
	logic [1:0]  evt_q;
	logic [1:0]  evt_d;
	logic [1:0]  evt_mask_q;
	logic [31:0] prdata_d;

	// ****************************************
	// request lines and classes
	// ****************************************
	logic [31:0] req_line;
	logic [31:0] active;
	logic [31:0] fast_act;
	logic [31:0] norm_act;
	logic [31:0] win_addr;

	// channel 1 has no peripheral: only its software bit counts
	assign req_line = {req_s2_q[31:2], 1'b0, req_s2_q[0]}
		| soft_q;  // [RULE13] [RULE12]
	assign active   = req_line & enable_q;
	assign fast_act = active & class_q;   // [RULE1]
	assign norm_act = active & ~class_q;  // [RULE1] [RULE7]

	// ****************************************
	// vectored slots
	// ****************************************
	vip_pick_if pk ();

	genvar g;
	generate
		for (g = 0; g < vip_pkg::N_SLOT; g++) begin : g_slot
			// a fast source never counts as vectored
			assign pk.hit[g] = slot_en_q[g]
				& norm_act[slot_src_q[g]];  // [RULE5] [RULE7]
		end
	endgenerate

	vip_slot_pick u_pick (
		.pk (pk)
	);

	assign win_addr = pk.valid ? slot_addr_q[pk.index]
		: default_q;  // [RULE9] [RULE10]

	// ****************************************
	// apb decode
	// ****************************************
	logic        setup_rd;
	logic        acc_wr;
	logic        acc_rd;
	logic        in_slot_addr;
	logic        in_slot_ctl;
	logic [3:0]  slot_idx;
	logic        mapped;

	function automatic logic in_range(input logic [11:0] a,
		input logic [11:0] base);
		in_range = (a >= base) && (a < base + vip_pkg::SLOT_SPAN);
	endfunction : in_range

	function automatic logic is_reg(input logic [11:0] a,
		input logic [11:0] off);
		is_reg = (a == off);
	endfunction : is_reg

	assign setup_rd     = psel_in & ~penable_in & ~pwrite_in;
	assign acc_wr       = psel_in & penable_in & pwrite_in & mapped;
	assign acc_rd       = psel_in & penable_in & ~pwrite_in;
	assign in_slot_addr = in_range(paddr_in, vip_pkg::OFF_SLOT_ADDR);
	assign in_slot_ctl  = in_range(paddr_in, vip_pkg::OFF_SLOT_CTL);
	assign slot_idx     = paddr_in[5:2];
	assign mapped       = (paddr_in[1:0] == 2'h0)
		&& (paddr_in <= vip_pkg::OFF_EVT_MASK
		|| in_slot_addr || in_slot_ctl);

	// zero wait states; unmapped or misaligned access errors
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~mapped;

	// ****************************************
	// read data, captured in the setup cycle
	// ****************************************
	always_comb begin
		prdata_d = 32'h0000_0000;
		if (!mapped) begin
			prdata_d = 32'h0000_0000;
		end else if (is_reg(paddr_in, vip_pkg::OFF_NORM_STAT)) begin
			prdata_d = norm_act;  // [RULE11]
		end else if (is_reg(paddr_in, vip_pkg::OFF_FAST_STAT)) begin
			prdata_d = fast_act;  // [RULE4]
		end else if (is_reg(paddr_in, vip_pkg::OFF_RAW_STAT)) begin
			prdata_d = req_line;
		end else if (is_reg(paddr_in, vip_pkg::OFF_ENABLE)) begin
			prdata_d = enable_q;
		end else if (is_reg(paddr_in, vip_pkg::OFF_CLASS)) begin
			prdata_d = class_q;
		end else if (is_reg(paddr_in, vip_pkg::OFF_SOFT)) begin
			prdata_d = soft_q;
		end else if (is_reg(paddr_in, vip_pkg::OFF_DEF_ADDR)) begin
			prdata_d = default_q;
		end else if (is_reg(paddr_in, vip_pkg::OFF_VECT_ADDR)) begin
			prdata_d = vect_addr_q;  // [RULE9] [RULE10]
		end else if (is_reg(paddr_in, vip_pkg::OFF_EVT_STAT)) begin
			prdata_d = {30'h0, evt_q};
		end else if (is_reg(paddr_in, vip_pkg::OFF_EVT_MASK)) begin
			prdata_d = {30'h0, evt_mask_q};
		end else if (in_slot_addr) begin
			prdata_d = slot_addr_q[slot_idx];
		end else if (in_slot_ctl) begin
			prdata_d = {26'h0, slot_en_q[slot_idx],
				slot_src_q[slot_idx]};
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_out <= vip_pkg::RST_WORD;
		end else if (setup_rd) begin
			prdata_out <= prdata_d;
		end
	end

	// ****************************************
	// input synchroniser
	// ****************************************
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			req_s1_q <= vip_pkg::RST_WORD;
			req_s2_q <= vip_pkg::RST_WORD;
		end else begin
			req_s1_q <= req_in;    // [RULE14]
			req_s2_q <= req_s1_q;  // [RULE14]
		end
	end

	// ****************************************
	// configuration writes
	// ****************************************
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			enable_q   <= vip_pkg::RST_WORD;  // [RULE14]
			class_q    <= vip_pkg::RST_WORD;  // [RULE14]
			soft_q     <= vip_pkg::RST_WORD;
			default_q  <= vip_pkg::RST_WORD;
			evt_mask_q <= vip_pkg::RST_EVT;
		end else if (acc_wr) begin
			if (is_reg(paddr_in, vip_pkg::OFF_ENABLE)) begin
				enable_q <= pwdata_in;  // [RULE2]
			end else if (is_reg(paddr_in, vip_pkg::OFF_CLASS)) begin
				class_q <= pwdata_in;  // [RULE2]
			end else if (is_reg(paddr_in, vip_pkg::OFF_SOFT)) begin
				soft_q <= pwdata_in;
			end else if (is_reg(paddr_in, vip_pkg::OFF_DEF_ADDR)) begin
				default_q <= pwdata_in;
			end else if (is_reg(paddr_in, vip_pkg::OFF_EVT_MASK)) begin
				evt_mask_q <= pwdata_in[1:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slot_en_q <= 16'h0000;  // [RULE14]
			for (int i = 0; i < vip_pkg::N_SLOT; i++) begin
				slot_addr_q[i] <= vip_pkg::RST_WORD;
				slot_src_q[i]  <= vip_pkg::RST_SRC;
			end
		end else if (acc_wr && in_slot_addr) begin
			slot_addr_q[slot_idx] <= pwdata_in;
		end else if (acc_wr && in_slot_ctl) begin
			// any source may sit in any slot
			slot_src_q[slot_idx] <= pwdata_in[4:0];  // [RULE5] [RULE2]
			slot_en_q[slot_idx]  <=
				pwdata_in[vip_pkg::SLOT_EN_BIT];  // [RULE2]
		end
	end

	// ****************************************
	// outputs to the core and vector
	// ****************************************
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fast_request_out   <= vip_pkg::RST_BIT;
			normal_request_out <= vip_pkg::RST_BIT;
			vect_addr_q        <= vip_pkg::RST_WORD;
		end else begin
			fast_request_out   <= |fast_act;  // [RULE3] [RULE14]
			normal_request_out <= |norm_act;  // [RULE8] [RULE14]
			vect_addr_q        <= win_addr;   // [RULE15]
		end
	end

	// ****************************************
	// event status, read clears, set wins
	// ****************************************
	logic [1:0] evt_set;
	logic       evt_clr;

	assign evt_set = {(|norm_act) & ~normal_request_out,
		(|fast_act) & ~fast_request_out};
	assign evt_clr = acc_rd & is_reg(paddr_in, vip_pkg::OFF_EVT_STAT);
	// clear only the bits this read reported: one set in setup survives
	assign evt_d   = (evt_clr ? evt_q & ~prdata_out[1:0] : evt_q)
		| evt_set;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			evt_q  <= vip_pkg::RST_EVT;
			irq_out <= vip_pkg::RST_BIT;
		end else begin
			evt_q  <= evt_d;
			irq_out <= |(evt_d & evt_mask_q);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_fast_or_out: assert property (  // [RULE3]
		(|fast_act) |=> fast_request_out)
		else $error("fast request not raised");

	a_fast_drop: assert property (  // [RULE3]
		!(|fast_act) |=> !fast_request_out)
		else $error("fast request held without source");

	a_normal_or_out: assert property (  // [RULE8]
		(|norm_act) == $past(|norm_act) |=>
		normal_request_out == $past(|norm_act))
		else $error("normal request wrong");

	a_sync_two_stage: assert property (  // [RULE14]
		##2 req_s2_q == $past(req_in, 2))
		else $error("request sampling latency wrong");

	a_soft_only_ch: assert property (  // [RULE13]
		!soft_q[1] |-> !req_line[1])
		else $error("channel one took a hardware request");

	a_class_disjoint: assert property (  // [RULE1]
		(fast_act & norm_act) == 32'h0 &&
		(fast_act | norm_act) == active)
		else $error("source in more than one class");

	a_slot_priority: assert property (  // [RULE6]
		pk.valid |-> pk.hit[pk.index] &&
		(pk.hit & ((16'h0001 << pk.index) - 16'h0001)) == 16'h0)
		else $error("lower slot lost arbitration");

	a_vect_not_fast: assert property (  // [RULE7]
		pk.valid |-> !fast_act[slot_src_q[pk.index]])
		else $error("fast source taken as vectored");

	a_vect_winner: assert property (  // [RULE9]
		pk.valid |=>
		vect_addr_q == $past(slot_addr_q[pk.index]))
		else $error("vector not winning slot address");

	a_vect_default: assert property (  // [RULE10]
		!pk.valid |=> vect_addr_q == $past(default_q))
		else $error("vector not default address");

	a_vect_read: assert property (  // [RULE15]
		setup_rd && is_reg(paddr_in, vip_pkg::OFF_VECT_ADDR)
		|=> prdata_out == $past(vect_addr_q))
		else $error("vector read not current value");

	a_fast_status: assert property (  // [RULE4]
		setup_rd && is_reg(paddr_in, vip_pkg::OFF_FAST_STAT)
		|=> prdata_out == $past(fast_act))
		else $error("fast status read wrong");

	a_norm_status: assert property (  // [RULE11]
		setup_rd && is_reg(paddr_in, vip_pkg::OFF_NORM_STAT)
		|=> prdata_out == $past(norm_act))
		else $error("normal status read wrong");

	a_class_write: assert property (  // [RULE2]
		acc_wr && is_reg(paddr_in, vip_pkg::OFF_CLASS)
		|=> class_q == $past(pwdata_in))
		else $error("class write not applied");

	a_slot_write: assert property (  // [RULE5]
		acc_wr && in_slot_ctl
		|=> slot_src_q[$past(slot_idx)] == $past(pwdata_in[4:0]))
		else $error("slot source write not applied");

	a_evt_set_wins: assert property (  // [RULE3] [RULE8]
		(|evt_set) |=> (evt_q & $past(evt_set)) == $past(evt_set))
		else $error("event lost to a clear");

	a_evt_read_clr: assert property (  // [RULE3] [RULE8]
		evt_clr && !(|evt_set)
		|=> (evt_q & $past(prdata_out[1:0])) == 2'h0)
		else $error("reported event not cleared");

	a_irq_needs_evt: assert property (  // [RULE3] [RULE8]
		irq_out |-> evt_q != 2'h0)
		else $error("interrupt without status bit");
endmodule : vip_request_prioritizer

// File: test/vip_core_model.sv
// processor core model counting entries into fast and normal service
`timescale 1ns/1ps
module vip_core_model (
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       fast_in,
	input  wire logic       normal_in,
	output logic      [7:0] fast_cnt_out,
	output logic      [7:0] norm_cnt_out
);
	logic fast_q;
	logic norm_q;

	// the core sees levels only, so an entry is a rising edge
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fast_q       <= 1'b0;
			norm_q       <= 1'b0;
			fast_cnt_out <= 8'h00;
			norm_cnt_out <= 8'h00;
		end else begin
			fast_q <= fast_in;
			norm_q <= normal_in;
			if (fast_in && !fast_q)
				fast_cnt_out <= fast_cnt_out + 8'h01;
			if (normal_in && !norm_q)
				norm_cnt_out <= norm_cnt_out + 8'h01;
		end
	end
endmodule : vip_core_model

// File: test/tb_vip_request_prioritizer.sv
// testbench of the request prioritizer over apb
`timescale 1ns/1ps
module tb_vip_request_prioritizer;
	logic        clk_in;
	logic        reset_n_in;
	logic [31:0] req_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        fast_request_out;
	logic        normal_request_out;
	logic        irq_out;
	logic [7:0]  fast_cnt;
	logic [7:0]  norm_cnt;
	logic [31:0] rdat;
	logic [31:0] rerr;
	int          n_fail;
	int          cmp_count;

	vip_request_prioritizer uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.req_in(req_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .fast_request_out(fast_request_out),
		.normal_request_out(normal_request_out), .irq_out(irq_out));
	vip_core_model core (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.fast_in(fast_request_out), .normal_in(normal_request_out),
		.fast_cnt_out(fast_cnt), .norm_cnt_out(norm_cnt));

	always #25 clk_in = ~clk_in;

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk_in);
			if (pready_out === 1'b1)
				break;
		end
		if (n == 16) begin
			n_fail++;
			close_out();
		end
		rdat       = prdata_out;
		rerr       = {31'h0, pslverr_out};
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd

	// synchronizer plus output register, with margin
	task settle;
		repeat (5) @(posedge clk_in);
	endtask : settle

	initial begin
		clk_in     = 1'b0;
		reset_n_in = 1'b0;
		req_in     = 32'h0;
		psel_in    = 1'b0;
		penable_in = 1'b0;
		pwrite_in  = 1'b0;
		paddr_in   = 12'h000;
		pwdata_in  = 32'h0;
		repeat (4) @(posedge clk_in);
		reset_n_in <= 1'b1;
		chk({31'h0, fast_request_out}, 32'h0);
		rd(vip_pkg::OFF_ENABLE, 32'h0);
		rd(vip_pkg::OFF_SLOT_CTL, 32'h0);
		wr(vip_pkg::OFF_DEF_ADDR, 32'h0000_0d0c);
		for (int i = 0; i < 16; i++)
			wr(vip_pkg::OFF_SLOT_ADDR + 12'(4 * i), 32'h0000_0a00 + i);
		rd(vip_pkg::OFF_SLOT_ADDR + 12'h03c, 32'h0000_0a0f);
		wr(vip_pkg::OFF_SLOT_CTL + 12'h00c, 32'h0000_0025);
		wr(vip_pkg::OFF_SLOT_CTL, 32'h0000_0026);
		wr(vip_pkg::OFF_EVT_MASK, 32'h0000_0003);
		wr(vip_pkg::OFF_CLASS, 32'h0000_0010);
		wr(vip_pkg::OFF_ENABLE, 32'h0000_00f0);
		req_in <= 32'h0000_0010;
		settle();
		chk({31'h0, fast_request_out}, 32'h1);
		chk({31'h0, normal_request_out}, 32'h0);
		chk({24'h0, fast_cnt}, 32'h1);
		chk({31'h0, irq_out}, 32'h1);
		rd(vip_pkg::OFF_FAST_STAT, 32'h0000_0010);
		rd(vip_pkg::OFF_EVT_STAT, 32'h0000_0001);
		// irq_out drops on the clearing edge itself: look once it settles
		@(negedge clk_in);
		chk({31'h0, irq_out}, 32'h0);
		rd(vip_pkg::OFF_EVT_STAT, 32'h0);
		req_in <= 32'h0000_00f0;
		settle();
		chk({31'h0, normal_request_out}, 32'h1);
		chk({31'h0, fast_request_out}, 32'h1);
		rd(vip_pkg::OFF_VECT_ADDR, 32'h0000_0a00);
		rd(vip_pkg::OFF_NORM_STAT, 32'h0000_00e0);
		req_in <= 32'h0000_00b0;
		settle();
		rd(vip_pkg::OFF_VECT_ADDR, 32'h0000_0a03);
		wr(vip_pkg::OFF_CLASS, 32'h0000_0030);
		settle();
		rd(vip_pkg::OFF_VECT_ADDR, 32'h0000_0d0c);
		rd(vip_pkg::OFF_FAST_STAT, 32'h0000_0030);
		wr(vip_pkg::OFF_EVT_MASK, 32'h0);
		req_in <= 32'h0000_0002;
		wr(vip_pkg::OFF_ENABLE, 32'h0000_0002);
		settle();
		chk({31'h0, irq_out}, 32'h0);
		rd(vip_pkg::OFF_RAW_STAT, 32'h0);
		chk({31'h0, normal_request_out}, 32'h0);
		wr(vip_pkg::OFF_SOFT, 32'h0000_0002);
		settle();
		rd(vip_pkg::OFF_RAW_STAT, 32'h0000_0002);
		chk({31'h0, normal_request_out}, 32'h1);
		rd(vip_pkg::OFF_EVT_STAT, 32'h0000_0002);
		chk({24'h0, norm_cnt}, 32'h2);
		chk({24'h0, fast_cnt}, 32'h1);
		rd(12'h0fc, 32'h0);
		chk(rerr, 32'h1);
		close_out();
	end
endmodule : tb_vip_request_prioritizer
